// ### stl_map.svh
/*
 Constants of the scan-port instruction logic: opcodes, register lengths,
 reset values. Assumes inclusion by bare name from the package and designs.
*/
`ifndef STL_MAP_SVH
`define STL_MAP_SVH

`define STL_IR_W      3
`define STL_IR_CAPT   3'h1
`define STL_OP_EXTEST 3'h0
`define STL_OP_IDCODE 3'h1
`define STL_OP_HIGHZ  3'h2
`define STL_OP_SAMPLE 3'h4
`define STL_OP_BYPASS 3'h7
`define STL_ID_W      32
// Arbitrary neutral value; bit 0 marks that an ID register is present
`define STL_ID_VALUE  32'h0ABC_DE01
`define STL_BSR_LEN   109
`define STL_PIN_N     108
`define STL_TRI_BIT   108
`define STL_TLR_TMS   5

`endif

// ### stl_pkg.sv
/*
 Types of the scan-port instruction logic: controller states and opcodes.
 Assumes stl_map.svh is on the include path.
*/
`include "stl_map.svh"

package stl_pkg;

    typedef enum logic [3:0] {
        TAP_TLR = 4'h0, TAP_RTI = 4'h1, TAP_SELDR = 4'h2, TAP_CAPDR = 4'h3,
        TAP_SHDR = 4'h4, TAP_EX1DR = 4'h5, TAP_PADR = 4'h6, TAP_EX2DR = 4'h7,
        TAP_UPDDR = 4'h8, TAP_SELIR = 4'h9, TAP_CAPIR = 4'hA, TAP_SHIR = 4'hB,
        TAP_EX1IR = 4'hC, TAP_PAIR = 4'hD, TAP_EX2IR = 4'hE, TAP_UPDIR = 4'hF
    } stl_tap_t;

    typedef enum logic [2:0] {
        OP_EXTEST = `STL_OP_EXTEST,
        OP_IDCODE = `STL_OP_IDCODE,
        OP_HIGHZ  = `STL_OP_HIGHZ,
        OP_SAMPLE = `STL_OP_SAMPLE,
        OP_BYPASS = `STL_OP_BYPASS
    } stl_op_t;

    typedef enum logic [1:0] {
        PATH_BYP = 2'h0,
        PATH_ID  = 2'h1,
        PATH_BSR = 2'h2
    } stl_path_t;

endpackage

// ### stl_sync3.sv
/*
 Three-stage synchroniser; a bit changes once stages two and three agree.
 Assumes din is asynchronous to clk.
*/
module stl_sync3
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout_q
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            dout_q <= '0;
        end
        else if (ce)
        begin
            s1_q   <= din;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            dout_q <= (s2_q & ~(s2_q ^ s3_q)) | (dout_q & (s2_q ^ s3_q));
        end
    end

endmodule // stl_sync3

// ### stl_tap_fsm.sv
/*
 Sixteen-state test access port controller, advanced by tms on rising tck.
 Assumes tms is launched by the tester relative to tck.
*/
`include "stl_map.svh"

module stl_tap_fsm
(
    input  wire logic         tck,
    input  wire logic         sys_rst,
    input  wire logic         tms,
    output var  stl_pkg::stl_tap_t state_q
);

    stl_pkg::stl_tap_t state_d;
    logic [2:0]        ones_q;

    always_comb
    begin
        unique case (state_q)
            stl_pkg::TAP_TLR:   state_d = tms ? stl_pkg::TAP_TLR   : stl_pkg::TAP_RTI;
            stl_pkg::TAP_RTI:   state_d = tms ? stl_pkg::TAP_SELDR : stl_pkg::TAP_RTI;
            stl_pkg::TAP_SELDR: state_d = tms ? stl_pkg::TAP_SELIR : stl_pkg::TAP_CAPDR;
            stl_pkg::TAP_CAPDR: state_d = tms ? stl_pkg::TAP_EX1DR : stl_pkg::TAP_SHDR;
            stl_pkg::TAP_SHDR:  state_d = tms ? stl_pkg::TAP_EX1DR : stl_pkg::TAP_SHDR;
            stl_pkg::TAP_EX1DR: state_d = tms ? stl_pkg::TAP_UPDDR : stl_pkg::TAP_PADR;
            stl_pkg::TAP_PADR:  state_d = tms ? stl_pkg::TAP_EX2DR : stl_pkg::TAP_PADR;
            stl_pkg::TAP_EX2DR: state_d = tms ? stl_pkg::TAP_UPDDR : stl_pkg::TAP_SHDR;
            stl_pkg::TAP_UPDDR: state_d = tms ? stl_pkg::TAP_SELDR : stl_pkg::TAP_RTI;
            stl_pkg::TAP_SELIR: state_d = tms ? stl_pkg::TAP_TLR   : stl_pkg::TAP_CAPIR;
            stl_pkg::TAP_CAPIR: state_d = tms ? stl_pkg::TAP_EX1IR : stl_pkg::TAP_SHIR;
            stl_pkg::TAP_SHIR:  state_d = tms ? stl_pkg::TAP_EX1IR : stl_pkg::TAP_SHIR;
            stl_pkg::TAP_EX1IR: state_d = tms ? stl_pkg::TAP_UPDIR : stl_pkg::TAP_PAIR;
            stl_pkg::TAP_PAIR:  state_d = tms ? stl_pkg::TAP_EX2IR : stl_pkg::TAP_PAIR;
            stl_pkg::TAP_EX2IR: state_d = tms ? stl_pkg::TAP_UPDIR : stl_pkg::TAP_SHIR;
            stl_pkg::TAP_UPDIR: state_d = tms ? stl_pkg::TAP_SELDR : stl_pkg::TAP_RTI;
        endcase
    end

    always_ff @(posedge tck or posedge sys_rst)
    begin
        if (sys_rst)
            state_q <= stl_pkg::TAP_TLR;
        else
            state_q <= state_d; // R19 R24
    end

    // Run of consecutive high tms samples, saturating
    always_ff @(posedge tck or posedge sys_rst)
    begin
        if (sys_rst)
            ones_q <= 3'h0;
        else if (!tms)
            ones_q <= 3'h0;
        else if (ones_q != 3'(`STL_TLR_TMS))
            ones_q <= ones_q + 3'h1;
    end

    tms_reset_a: assert property ( // R24
        @(posedge tck) disable iff (sys_rst)
        ones_q == 3'(`STL_TLR_TMS) |-> state_q == stl_pkg::TAP_TLR)
        else $error("five high tms samples did not reach reset state");

endmodule // stl_tap_fsm

// ### stl_tap_top.sv
/*
 Test access port of a synchronous memory: instruction register, ID,
 bypass and 109-cell boundary register, and the hand-off of extest drive
 and output-bus enable to the memory's clock domain.
 Assumes tck, tms, tdi come from a board tester; pin_in is the pin ring,
 asynchronous to tck; the memory side reads the outputs on clk.
*/
// Behaviour
// R1 - ID capture loads fixed 32-bit value
// R2 - Hardwired ID shifts out in Shift-DR
// R3 - Three-bit instruction register, five codes used
// R4 - Tester never loads the reserved codes
// R5 - Instruction register sits between TDI/TDO
// R6 - New instruction applies only at Update-IR
// R7 - Reset and Test-Logic-Reset select ID instruction
// R8 - High-Z sample: boundary path, output bus off
// R9 - Sample captures all pin values in Capture-DR
// R10 - Tester holds captured pins stable around capture
// R11 - Boundary register shifts during Shift-DR
// R12 - Preload latches shifted pattern to cell outputs
// R13 - Sample out and preload in share one pass
// R14 - Bypass instruction selects bypass register alone
// R15 - Extest drives preloaded values, boundary path
// R16 - Cell 108 gates output bus under extest
// R17 - Update-DR latches shifted control cell value
// R18 - Control latch presets to one at reset
// R19 - Transitions follow tms on rising tck
// R20 - Instruction codes 000,001,010,100,111; others reserved
// R21 - Inputs on rising tck, TDO on falling
// R22 - Capture-IR loads 01 into low bits
// R23 - Bypass register is a single bit
// R24 - Full sixteen-state controller, five-TMS reset
// R25 - TDO off outside shifts; no disturbance
`include "stl_map.svh"

module stl_tap_top
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  clk_en,
    input  wire logic                  tck,
    input  wire logic                  tms,
    input  wire logic                  tdi,
    output var  logic                  tdo_q,
    output var  logic                  tdo_oe_q,
    input  wire logic [`STL_PIN_N-1:0] pin_in,
    output var  logic                  ext_drive_q,
    output var  logic [`STL_PIN_N-1:0] ext_pin_q,
    output var  logic                  qbus_oe_q
);

    stl_pkg::stl_tap_t       st;
    logic [`STL_PIN_N-1:0]   pin_s;
    logic [`STL_IR_W-1:0]    ir_sh_q;
    logic [`STL_IR_W-1:0]    ir_q;
    logic [`STL_ID_W-1:0]    id_q;
    logic                    byp_q;
    logic [`STL_BSR_LEN-1:0] bsr_q;
    logic [`STL_BSR_LEN-1:0] pre_q;
    logic                    tgl_q;
    logic                    tgl_s;
    logic                    seen_q;
    logic                    take;
    stl_pkg::stl_path_t      path;
    logic                    in_tlr;
    logic                    in_capdr;
    logic                    in_shdr;
    logic                    in_upddr;
    logic                    in_capir;
    logic                    in_shir;
    logic                    in_updir;
    logic                    pre_ok;
    logic                    dr_bit;

    // Reserved codes fall back to the bypass path so a stray load keeps the
    // chain length predictable
    function automatic stl_pkg::stl_path_t path_of(logic [`STL_IR_W-1:0] op);
        unique case (op)
            `STL_OP_IDCODE: path_of = stl_pkg::PATH_ID;
            `STL_OP_EXTEST,
            `STL_OP_HIGHZ,
            `STL_OP_SAMPLE: path_of = stl_pkg::PATH_BSR;
            `STL_OP_BYPASS: path_of = stl_pkg::PATH_BYP;
            default:        path_of = stl_pkg::PATH_BYP;
        endcase
    endfunction

    stl_tap_fsm u_fsm
    (
        .tck     (tck),
        .sys_rst (sys_rst),
        .tms     (tms),
        .state_q (st)
    );

    // Pin ring is asynchronous to tck, so it is filtered before capture
    stl_sync3 #(.W(`STL_PIN_N)) u_pin_sync
    (
        .clk     (tck),
        .sys_rst (sys_rst),
        .ce      (1'b1),
        .din     (pin_in),
        .dout_q  (pin_s)
    );

    assign in_tlr   = (st == stl_pkg::TAP_TLR);
    assign in_capdr = (st == stl_pkg::TAP_CAPDR);
    assign in_shdr  = (st == stl_pkg::TAP_SHDR);
    assign in_upddr = (st == stl_pkg::TAP_UPDDR);
    assign in_capir = (st == stl_pkg::TAP_CAPIR);
    assign in_shir  = (st == stl_pkg::TAP_SHIR);
    assign in_updir = (st == stl_pkg::TAP_UPDIR);
    assign path     = path_of(ir_q);
    assign pre_ok   = (ir_q == `STL_OP_SAMPLE) || (ir_q == `STL_OP_EXTEST);

    // Instruction shift stage
    always_ff @(posedge tck or posedge sys_rst)
    begin
        if (sys_rst)
            ir_sh_q <= `STL_IR_CAPT;
        else if (in_capir)
            ir_sh_q <= `STL_IR_CAPT; // R22
        else if (in_shir)
            ir_sh_q <= {tdi, ir_sh_q[`STL_IR_W-1:1]}; // R5
    end

    // Current instruction
    always_ff @(posedge tck or posedge sys_rst)
    begin
        if (sys_rst)
            ir_q <= `STL_OP_IDCODE; // R7
        else if (in_tlr)
            ir_q <= `STL_OP_IDCODE; // R7
        else if (in_updir)
            ir_q <= ir_sh_q; // R6 R3 R20
    end

    // Identification register
    always_ff @(posedge tck or posedge sys_rst)
    begin
        if (sys_rst)
            id_q <= `STL_ID_VALUE;
        else if (path == stl_pkg::PATH_ID)
        begin
            if (in_capdr)
                id_q <= `STL_ID_VALUE; // R1
            else if (in_shdr)
                id_q <= {tdi, id_q[`STL_ID_W-1:1]}; // R2
        end
    end

    // Single-bit bypass register, captures zero
    always_ff @(posedge tck or posedge sys_rst)
    begin
        if (sys_rst)
            byp_q <= 1'b0;
        else if (path == stl_pkg::PATH_BYP)
        begin
            if (in_capdr)
                byp_q <= 1'b0;
            else if (in_shdr)
                byp_q <= tdi; // R14 R23
        end
    end

    // Boundary register; the control cell has no pin, so it captures its
    // own latched value
    always_ff @(posedge tck or posedge sys_rst)
    begin
        if (sys_rst)
            bsr_q <= '0;
        else if (path == stl_pkg::PATH_BSR)
        begin
            if (in_capdr)
                bsr_q <= {pre_q[`STL_TRI_BIT], pin_s}; // R9
            else if (in_shdr)
                bsr_q <= {tdi, bsr_q[`STL_BSR_LEN-1:1]}; // R11 R13 R8 R15
        end
    end

    // Preload latch stage
    always_ff @(posedge tck or posedge sys_rst)
    begin
        if (sys_rst)
            pre_q <= {1'b1, {`STL_PIN_N{1'b0}}}; // R18
        else if (in_tlr)
            pre_q[`STL_TRI_BIT] <= 1'b1; // R18
        else if (in_upddr && pre_ok)
            pre_q <= bsr_q; // R12 R17
    end

    // Data-register bit presented at tdo
    always_comb
    begin
        unique case (path)
            stl_pkg::PATH_ID:  dr_bit = id_q[0];
            stl_pkg::PATH_BSR: dr_bit = bsr_q[0];
            stl_pkg::PATH_BYP: dr_bit = byp_q;
            default:           dr_bit = byp_q;
        endcase
    end

    // Falling-edge output gives the tester half a period of hold
    always_ff @(negedge tck or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end
        else
        begin
            tdo_q    <= in_shir ? ir_sh_q[0] : dr_bit; // R21 R5
            tdo_oe_q <= in_shir || in_shdr; // R25
        end
    end

    // Announces new instruction or preload contents to the clk side; the
    // announced registers then hold for many clk cycles, which makes the
    // toggle a safe handshake. Back-to-back updates closer than the sync
    // delay would be merged, which tck limits rule out.
    always_ff @(posedge tck or posedge sys_rst)
    begin
        if (sys_rst)
            tgl_q <= 1'b0;
        else if (in_tlr || in_updir || in_upddr)
            tgl_q <= ~tgl_q;
    end

    stl_sync3 #(.W(1)) u_tgl_sync
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (clk_en),
        .din     (tgl_q),
        .dout_q  (tgl_s)
    );

    assign take = clk_en && (tgl_s != seen_q);

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            seen_q <= 1'b0;
        else if (take)
            seen_q <= tgl_s;
    end

    // Memory-side view; only extest drives pins, so other instructions except
    // high-z leave normal operation alone
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ext_drive_q <= 1'b0;
            ext_pin_q   <= '0;
        end
        else if (take)
        begin
            ext_drive_q <= (ir_q == `STL_OP_EXTEST); // R15 R25
            ext_pin_q   <= pre_q[`STL_PIN_N-1:0]; // R15
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            qbus_oe_q <= 1'b1;
        else if (take)
        begin
            if (ir_q == `STL_OP_HIGHZ)
                qbus_oe_q <= 1'b0; // R8
            else if (ir_q == `STL_OP_EXTEST)
                qbus_oe_q <= pre_q[`STL_TRI_BIT]; // R16
            else
                qbus_oe_q <= 1'b1;
        end
    end

    id_capture_a: assert property ( // R1
        @(posedge tck) disable iff (sys_rst)
        in_capdr && ir_q == `STL_OP_IDCODE |=> id_q == `STL_ID_VALUE)
        else $error("id value not captured");

    id_shift_a: assert property ( // R2
        @(posedge tck) disable iff (sys_rst)
        in_shdr && path == stl_pkg::PATH_ID
        |=> id_q == {$past(tdi), $past(id_q[`STL_ID_W-1:1])})
        else $error("id register did not shift");

    ir_capture_a: assert property ( // R22
        @(posedge tck) disable iff (sys_rst)
        in_capir |=> ir_sh_q[1:0] == 2'h1)
        else $error("capture-ir pattern wrong");

    ir_update_a: assert property ( // R6
        @(posedge tck) disable iff (sys_rst)
        in_updir |=> ir_q == $past(ir_sh_q))
        else $error("instruction not applied at update");

    ir_hold_a: assert property ( // R6
        @(posedge tck) disable iff (sys_rst)
        !in_updir && !in_tlr |=> $stable(ir_q))
        else $error("instruction changed outside update");

    ir_reset_a: assert property ( // R7
        @(posedge tck) disable iff (sys_rst)
        in_tlr |=> ir_q == `STL_OP_IDCODE)
        else $error("reset did not select id instruction");

    bypass_path_a: assert property ( // R14
        @(posedge tck) disable iff (sys_rst)
        in_shdr && ir_q == `STL_OP_BYPASS ##1 !in_shir
        |-> ##0 tdo_q == $past(tdi) || !tdo_oe_q)
        else $error("bypass path not one bit");

    bsr_shift_a: assert property ( // R11
        @(posedge tck) disable iff (sys_rst)
        in_shdr && path == stl_pkg::PATH_BSR
        |=> bsr_q == {$past(tdi), $past(bsr_q[`STL_BSR_LEN-1:1])})
        else $error("boundary register did not shift");

    preload_latch_a: assert property ( // R17
        @(posedge tck) disable iff (sys_rst)
        in_upddr && pre_ok |=> pre_q == $past(bsr_q))
        else $error("preload not latched at update-dr");

    tri_preset_a: assert property ( // R18
        @(posedge tck) disable iff (sys_rst)
        in_tlr |=> pre_q[`STL_TRI_BIT])
        else $error("control cell not preset");

    tdo_enable_a: assert property ( // R25
        @(posedge tck) disable iff (sys_rst)
        ##1 tdo_oe_q == (in_shir || in_shdr))
        else $error("tdo enable wrong for state");

    hiz_bus_a: assert property ( // R8
        @(posedge clk) disable iff (sys_rst)
        take && ir_q == `STL_OP_HIGHZ |=> !qbus_oe_q && !ext_drive_q)
        else $error("output bus not off under high-z sample");

    extest_drive_a: assert property ( // R16
        @(posedge clk) disable iff (sys_rst)
        take && ir_q == `STL_OP_EXTEST
        |=> ext_drive_q && qbus_oe_q == $past(pre_q[`STL_TRI_BIT]))
        else $error("extest drive or bus control wrong");

endmodule // stl_tap_top

// ### stl_tester.sv
/*
 Board tester model for the scan port: makes tck only while stepping,
 steers tms, feeds tdi and samples tdo just before each rising tck.
 Assumes the port under test changes tdo and its enable on falling tck.
*/
module stl_tester
(
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi,
    input  wire logic tdo_q,
    input  wire logic tdo_oe_q
);
    timeunit 1ns;
    timeprecision 100ps;

    logic o;
    int   oe_err;

    // Lines rest at their pull-up level; tck stands low between frames
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        o = 1'b0;
        oe_err = 0;
    end

    // One 160 ns period; sh is the tdo enable expected before the rise
    task automatic step(input logic m, input logic d, input logic sh);
        tms = m;
        tdi = d;
        #80;
        o = tdo_q;
        if (tdo_oe_q !== sh)
        begin
            oe_err++;
        end
        tck = 1'b1;
        #80;
        tck = 1'b0;
    endtask

    // Shifts n bits LSB first out, leaving the shift state on the last one
    task automatic scan(input int n, input logic [127:0] din, output logic [127:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++)
        begin
            step(1'(i == n - 1), din[i], 1'b1);
            dout[i] = o;
        end
    endtask
endmodule // stl_tester

// ### test_sram_tap_instruction_logic.sv
/*
 Self-checking bench of the scan port: a tester model walks every opcode,
 a shadow of the instruction and preload latch predicts every result.
 Assumes stl_map.svh on the include path and the package compiled first.
*/
`include "stl_map.svh"

module test_sram_tap_instruction_logic;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic H = 1'b1;
    localparam logic L = 1'b0;

    logic                  clk;
    logic                  sys_rst;
    logic                  clk_en;
    logic                  tck;
    logic                  tms;
    logic                  tdi;
    logic                  tdo_q;
    logic                  tdo_oe_q;
    logic [`STL_PIN_N-1:0] pin_in;
    logic                  ext_drive_q;
    logic [`STL_PIN_N-1:0] ext_pin_q;
    logic                  qbus_oe_q;
    int                    n_mismatch;
    int                    checks_done;
    logic [31:0]           seed;
    logic [2:0]            cur_m;
    logic [108:0]          pre_m;
    logic [2:0]            codes [8];

    stl_tap_top stl_tap_top_i (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .pin_in(pin_in),
        .ext_drive_q(ext_drive_q), .ext_pin_q(ext_pin_q), .qbus_oe_q(qbus_oe_q));

    stl_tester stl_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo_q(tdo_q),
        .tdo_oe_q(tdo_oe_q));

    always #12.5 clk = ~clk;

    task automatic final_report();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    function automatic logic [127:0] rnd();
        logic [127:0] v;
        for (int i = 0; i < 128; i++)
        begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
            v[i] = seed[0];
        end
        return v;
    endfunction

    task automatic mv(input logic m);
        stl_tester_i.step(m, H, L);
    endtask

    // Handoff settles in 4..5 enabled clk edges
    task automatic wait8();
        repeat (8) @(posedge clk);
    endtask

    task automatic outs();
        logic exp_oe;
        wait8();
        chk(128'(ext_drive_q), 128'(cur_m == 3'h0));
        chk(128'(ext_pin_q), 128'(pre_m[107:0]));
        exp_oe = (cur_m == 3'h2) ? L : (cur_m == 3'h0) ? pre_m[108] : H;
        chk(128'(qbus_oe_q), 128'(exp_oe));
        chk(128'(stl_tester_i.oe_err), 128'h0);
    endtask

    task automatic ir_load(input logic [2:0] op, input logic pz);
        logic [127:0] o;
        mv(H);
        mv(H);
        mv(L);
        mv(L);
        stl_tester_i.scan(3, 128'(op), o);
        chk(o, 128'h1);
        if (pz)
        begin
            mv(L);
            wait8();
            chk(128'(ext_drive_q), 128'(cur_m == 3'h0));
            mv(H);
        end
        mv(H);
        mv(L);
        cur_m = op;
    endtask

    task automatic run_op(input logic [2:0] op, input logic load);
        logic [127:0] din;
        logic [127:0] cap;
        logic [127:0] out;
        logic [127:0] v;
        logic [127:0] msk;
        int           w;
        v = rnd();
        din = rnd();
        @(posedge clk);
        pin_in <= v[107:0];
        if (load)
            ir_load(op, L);
        // Flip the bus control cell on every sample preload so both values occur
        if (op == 3'h4)
            din[116] = ~pre_m[108];
        w = 1;
        cap = '0;
        if (op == 3'h1)
        begin
            w = `STL_ID_W;
            cap = 128'(`STL_ID_VALUE);
        end
        else if (op == 3'h0 || op == 3'h2 || op == 3'h4)
        begin
            w = `STL_BSR_LEN;
            cap = 128'({pre_m[108], v[107:0]});
        end
        // Eight extra bits expose the exact path length
        msk = {128{1'b1}} >> (120 - w);
        mv(H);
        mv(L);
        mv(L);
        stl_tester_i.scan(w + 8, din, out);
        mv(H);
        mv(L);
        chk(out & msk, (cap | (din << w)) & msk);
        if (op == 3'h0 || op == 3'h4)
            pre_m = din[116:8];
        outs();
    endtask

    initial
    begin
        repeat (90000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    initial
    begin
        clk = L;
        sys_rst = H;
        clk_en = H;
        pin_in = '0;
        n_mismatch = 0;
        checks_done = 0;
        seed = 32'h0000_005B;
        cur_m = 3'h1;
        pre_m = '0;
        pre_m[108] = H;
        // Reserved codes are never loaded; the last entry must not be extest
        codes = '{3'h4, 3'h0, 3'h2, 3'h1, 3'h7, 3'h0, 3'h4, 3'h2};
        fork
            repeat (20) @(posedge clk);
            begin
                mv(H);
                mv(H);
            end
        join
        sys_rst <= L;
        outs();
        mv(L);
        run_op(3'h1, L);
        for (int i = 0; i < 32; i++)
            run_op(codes[i % 8], H);
        // A handoff must wait while the memory side is disabled
        @(posedge clk);
        clk_en <= L;
        ir_load(3'h0, L);
        wait8();
        chk(128'(ext_drive_q), 128'h0);
        @(posedge clk);
        clk_en <= H;
        outs();
        ir_load(3'h4, H);
        outs();
        if (pre_m[108])
            run_op(3'h4, H);
        // Five high tms from Shift-IR reach reset
        mv(H);
        mv(H);
        mv(L);
        mv(L);
        stl_tester_i.step(H, H, H);
        repeat (4) mv(H);
        mv(L);
        cur_m = 3'h1;
        pre_m[108] = H;
        outs();
        run_op(3'h1, L);
        run_op(3'h4, H);
        final_report();
    end
endmodule // test_sram_tap_instruction_logic
